// *** sps_pkg.sv ***
// Constants and carrier types for the supply power-up sequencer.
// Assumes a single 20 MHz system clock; all inputs synchronous to it.
package sps_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 20000000;
  localparam int EN_DLY_MS = 11;
  localparam int MON_WAIT_MS = 10;
  localparam int RST_DLY_MS = 10;
  localparam int GLITCH_MIN_US = 20;
  localparam int GLITCH_MAX_US = 1000;
  localparam int EN_DLY_CYC = EN_DLY_MS * (CLK_HZ / 1000);
  localparam int MON_WAIT_CYC = MON_WAIT_MS * (CLK_HZ / 1000);
  localparam int RST_DLY_CYC = RST_DLY_MS * (CLK_HZ / 1000);
  // Filter window set to the least suppression time, rounded up
  localparam int GLITCH_CYC = (GLITCH_MIN_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int GLITCH_MAX_CYC = GLITCH_MAX_US * (CLK_HZ / 1000) / 1000;
  localparam int NUM_MON = 4;
  localparam int MON_MAIN = 3;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic ENABLE_RST = 1'b0;
  localparam logic SYS_RESET_N_RST = 1'b0;

  typedef struct packed {
    logic core;
    logic mid;
    logic io;
  } sps_rails_type;

  typedef enum logic [2:0] {
    SPS_OFF, SPS_EN_DLY, SPS_CORE_WAIT, SPS_MID_WAIT, SPS_IO_WAIT,
    SPS_RST_WAIT, SPS_ON, SPS_FAIL
  } sps_state_type;
endpackage

// *** sps_glitch_filter.sv ***
// Glitch filter for one supervisor comparator or request level.
// Assumes the input is already synchronous to CLK.
`timescale 1ns/100ps
module sps_glitch_filter #(
  parameter int FILT_CYC = 400
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic raw,
  input wire logic init,
  output logic filt
);
  localparam int CW = $clog2(FILT_CYC + 1);
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic filt_reg;
  logic filt_next;

  if (FILT_CYC < 1) begin : g_bad_filt
    $error("FILT_CYC must be at least one");
  end

  // Output follows the input only after it held steady FILT_CYC cycles
  always_comb begin
    cnt_next = cnt_reg;
    filt_next = filt_reg;
    if (raw == filt_reg) begin
      cnt_next = '0;
    end else if (cnt_reg == CW'(FILT_CYC - 1)) begin
      cnt_next = '0;
      filt_next = raw;
    end else begin
      cnt_next = cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= '0;
      filt_reg <= init;
    end else if (ce) begin
      cnt_reg <= cnt_next;
      filt_reg <= filt_next;
    end
  end

  assign filt = filt_reg;
endmodule

// *** sps_sequencer.sv ***
// Power-up sequencer and supply supervisor: top module.
// Assumes comparator outputs (rail good, main good) arrive synchronous.
//
// What this block does
// - Core rail enable rises 11 ms after a request rising edge.
// - Core rail monitor is sampled a full 10 ms after its enable.
// - Mid rail monitor is sampled a full 10 ms after its enable.
// - I/O rail monitor is sampled a full 10 ms after its enable.
// - Reset output is released 10 ms after the I/O test passes.
// - A failed test holds reset asserted and stops the sequence.
// - Rail monitor dips shorter than the glitch window are ignored.
// - Rail monitor trip and hysteresis come from the analog comparators.
// - Main supply crossings shorter than the window are ignored.
// - A low request is a host request to power down.
`timescale 1ns/100ps
module sps_sequencer #(
  parameter int EN_DLY_CYC = sps_pkg::EN_DLY_CYC,
  parameter int MON_WAIT_CYC = sps_pkg::MON_WAIT_CYC,
  parameter int RST_DLY_CYC = sps_pkg::RST_DLY_CYC,
  parameter int GLITCH_CYC = sps_pkg::GLITCH_CYC
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic CE,
  input wire logic PROJECTOR_POWER_REQUEST,
  input wire logic CORE_RAIL_GOOD,
  input wire logic MID_RAIL_GOOD,
  input wire logic IO_RAIL_GOOD,
  input wire logic MAIN_INPUT_SUPPLY_GOOD,
  output logic CORE_RAIL_ENABLE,
  output logic MID_RAIL_ENABLE,
  output logic IO_RAIL_ENABLE,
  output logic SYSTEM_RESET_N,
  output logic SEQUENCE_FAIL,
  output logic POWER_DOWN_REQUEST,
  output logic MAIN_SUPPLY_LOW
);
  localparam int MAXC = (EN_DLY_CYC > MON_WAIT_CYC) ? EN_DLY_CYC
                                                    : MON_WAIT_CYC;
  localparam int TW = $clog2(MAXC + RST_DLY_CYC + 1);

  if (EN_DLY_CYC <= GLITCH_CYC || MON_WAIT_CYC < 1 ||
      RST_DLY_CYC < 1) begin : g_bad_timing
    $error("Sequencer timing parameters out of range");
  end

  // ---------------------------------------------------------------
  // Input filters
  // ---------------------------------------------------------------
  logic [sps_pkg::NUM_MON-1:0] mon_raw;
  logic [sps_pkg::NUM_MON-1:0] mon_ok;
  logic req_filt;

  // Comparators give a falling trip and 2% hysteresis in the analog
  // front end; the digital side only sees the resulting level.
  assign mon_raw = {MAIN_INPUT_SUPPLY_GOOD, IO_RAIL_GOOD, MID_RAIL_GOOD,
                    CORE_RAIL_GOOD};

  genvar gi;
  generate
    for (gi = 0; gi < sps_pkg::NUM_MON; gi++) begin : g_mon
      sps_glitch_filter #(
        .FILT_CYC(GLITCH_CYC)
      ) u_filt (
        .clk(CLK),
        .rst(SYS_RST),
        .ce(CE),
        .raw(mon_raw[gi]),
        .init(1'b0),
        .filt(mon_ok[gi])
      );
    end
  endgenerate

  // Request filter time is part of the 11 ms enable delay
  sps_glitch_filter #(
    .FILT_CYC(GLITCH_CYC)
  ) u_req (
    .clk(CLK),
    .rst(SYS_RST),
    .ce(CE),
    .raw(PROJECTOR_POWER_REQUEST),
    .init(1'b0),
    .filt(req_filt)
  );

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  sps_pkg::sps_state_type state_reg;
  sps_pkg::sps_state_type state_next;
  logic [TW-1:0] tmr_reg;
  logic [TW-1:0] tmr_next;
  sps_pkg::sps_rails_type rails_reg;
  sps_pkg::sps_rails_type rails_next;
  logic rst_n_reg;
  logic rst_n_next;
  logic fail_reg;
  logic fail_next;
  logic req_d_reg;
  logic pdn_reg;
  logic pdn_next;
  logic main_low_reg;
  logic tmr_done;

  assign tmr_done = (tmr_reg == '0);

  always_comb begin
    state_next = state_reg;
    tmr_next = tmr_done ? tmr_reg : tmr_reg - 1'b1;
    rails_next = rails_reg;
    rst_n_next = rst_n_reg;
    fail_next = fail_reg;
    pdn_next = req_d_reg & ~req_filt;
    if (!req_filt) begin
      // Power-down: drop reset and all enables; failure latch cleared so
      // the host can restart from the beginning
      state_next = sps_pkg::SPS_OFF;
      rails_next = '0;
      rst_n_next = 1'b0;
      fail_next = 1'b0;
    end else begin
      unique case (state_reg)
        sps_pkg::SPS_OFF: begin
          if (!req_d_reg) begin
            state_next = sps_pkg::SPS_EN_DLY;
            tmr_next = TW'(EN_DLY_CYC - GLITCH_CYC - 1);
          end
        end
        sps_pkg::SPS_EN_DLY: begin
          if (tmr_done) begin
            rails_next.core = 1'b1;
            state_next = sps_pkg::SPS_CORE_WAIT;
            tmr_next = TW'(MON_WAIT_CYC - 1);
          end
        end
        sps_pkg::SPS_CORE_WAIT: begin
          if (tmr_done) begin
            if (mon_ok[0]) begin
              rails_next.mid = 1'b1;
              state_next = sps_pkg::SPS_MID_WAIT;
              tmr_next = TW'(MON_WAIT_CYC - 1);
            end else begin
              state_next = sps_pkg::SPS_FAIL;
            end
          end
        end
        sps_pkg::SPS_MID_WAIT: begin
          if (tmr_done) begin
            if (mon_ok[1]) begin
              rails_next.io = 1'b1;
              state_next = sps_pkg::SPS_IO_WAIT;
              tmr_next = TW'(MON_WAIT_CYC - 1);
            end else begin
              state_next = sps_pkg::SPS_FAIL;
            end
          end
        end
        sps_pkg::SPS_IO_WAIT: begin
          if (tmr_done) begin
            if (mon_ok[2]) begin
              state_next = sps_pkg::SPS_RST_WAIT;
              tmr_next = TW'(RST_DLY_CYC - 1);
            end else begin
              state_next = sps_pkg::SPS_FAIL;
            end
          end
        end
        sps_pkg::SPS_RST_WAIT: begin
          if (tmr_done) begin
            rst_n_next = 1'b1;
            state_next = sps_pkg::SPS_ON;
          end
        end
        sps_pkg::SPS_ON: begin
          // A filtered dip on any rail forces reset again
          if (mon_ok[2:0] != 3'h7) begin
            rst_n_next = 1'b0;
            state_next = sps_pkg::SPS_FAIL;
          end
        end
        sps_pkg::SPS_FAIL: begin
          // Hold here with reset asserted until the request drops
          fail_next = 1'b1;
          rst_n_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state_reg <= sps_pkg::SPS_OFF;
      tmr_reg <= '0;
      rails_reg <= {3{sps_pkg::ENABLE_RST}};
      rst_n_reg <= sps_pkg::SYS_RESET_N_RST;
      fail_reg <= 1'b0;
      req_d_reg <= 1'b0;
      pdn_reg <= 1'b0;
      main_low_reg <= 1'b0;
    end else if (CE) begin
      state_reg <= state_next;
      tmr_reg <= tmr_next;
      rails_reg <= rails_next;
      rst_n_reg <= rst_n_next;
      fail_reg <= fail_next;
      req_d_reg <= req_filt;
      pdn_reg <= pdn_next;
      main_low_reg <= ~mon_ok[sps_pkg::MON_MAIN];
    end
  end

  assign CORE_RAIL_ENABLE = rails_reg.core;
  assign MID_RAIL_ENABLE = rails_reg.mid;
  assign IO_RAIL_ENABLE = rails_reg.io;
  assign SYSTEM_RESET_N = rst_n_reg;
  assign SEQUENCE_FAIL = fail_reg;
  assign POWER_DOWN_REQUEST = pdn_reg;
  assign MAIN_SUPPLY_LOW = main_low_reg;
endmodule

// *** sps_sequencer_asserts.sv ***
// Port checker for the supply power-up sequencer.
// Bound into sps_sequencer; assumes CE stays high while checked.
`timescale 1ns/100ps
module sps_sequencer_asserts #(
  parameter int EN_DLY_CYC = 20,
  parameter int MON_WAIT_CYC = 10,
  parameter int RST_DLY_CYC = 10
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic PROJECTOR_POWER_REQUEST,
  input wire logic MAIN_INPUT_SUPPLY_GOOD,
  input wire logic CORE_RAIL_ENABLE,
  input wire logic MID_RAIL_ENABLE,
  input wire logic IO_RAIL_ENABLE,
  input wire logic SYSTEM_RESET_N,
  input wire logic SEQUENCE_FAIL,
  input wire logic POWER_DOWN_REQUEST,
  input wire logic MAIN_SUPPLY_LOW
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  sequence s_pulse_gone;
    ##1 !POWER_DOWN_REQUEST;
  endsequence
  core_delay_a: assert property ($rose(CORE_RAIL_ENABLE) |->
    $past(PROJECTOR_POWER_REQUEST, EN_DLY_CYC - 2)) else $error("core early");
  mid_order_a: assert property ($rose(MID_RAIL_ENABLE) |->
    $past(CORE_RAIL_ENABLE, MON_WAIT_CYC) &&
    !$past(CORE_RAIL_ENABLE, MON_WAIT_CYC + 1)) else $error("mid timing");
  io_order_a: assert property ($rose(IO_RAIL_ENABLE) |->
    $past(MID_RAIL_ENABLE, MON_WAIT_CYC) &&
    !$past(MID_RAIL_ENABLE, MON_WAIT_CYC + 1)) else $error("io timing");
  reset_delay_a: assert property ($rose(SYSTEM_RESET_N) |->
    $past(IO_RAIL_ENABLE, MON_WAIT_CYC + RST_DLY_CYC) &&
    !$past(IO_RAIL_ENABLE, MON_WAIT_CYC + RST_DLY_CYC + 1))
    else $error("reset timing");
  reset_rails_a: assert property (SYSTEM_RESET_N |->
    CORE_RAIL_ENABLE && MID_RAIL_ENABLE && IO_RAIL_ENABLE)
    else $error("reset without rails");
  fail_holds_a: assert property (SEQUENCE_FAIL |-> !SYSTEM_RESET_N)
    else $error("reset released in fail");
  fail_sticky_a: assert property (SEQUENCE_FAIL &&
    PROJECTOR_POWER_REQUEST && $past(PROJECTOR_POWER_REQUEST) |=>
    SEQUENCE_FAIL) else $error("fail cleared");
  down_pulse_a: assert property (POWER_DOWN_REQUEST |->
    !$past(PROJECTOR_POWER_REQUEST, 2) ##0 s_pulse_gone)
    else $error("bad power down pulse");
  main_clear_a: assert property ($fell(MAIN_SUPPLY_LOW) |->
    $past(MAIN_INPUT_SUPPLY_GOOD, 2)) else $error("main low cleared early");
endmodule
bind sps_sequencer sps_sequencer_asserts #(.EN_DLY_CYC(EN_DLY_CYC),
  .MON_WAIT_CYC(MON_WAIT_CYC), .RST_DLY_CYC(RST_DLY_CYC)) u_chk (.*);

// *** sps_rail_model.sv ***
// Model of the three external regulators and their monitors.
// Enables come from the sequencer; the bench picks early rails and dips.
`timescale 1ns/100ps
module sps_rail_model (
  input wire logic clk,
  input wire sps_pkg::sps_rails_type en,
  input wire sps_pkg::sps_rails_type early,
  input wire sps_pkg::sps_rails_type dead,
  input wire logic tied,
  output sps_pkg::sps_rails_type good
);
  sps_pkg::sps_rails_type on_reg [3];
  sps_pkg::sps_rails_type drive;
  // All three regulators may share the core enable
  assign drive = tied ? sps_pkg::sps_rails_type'({3{en.core}}) : en;
  // Rails ramp for three cycles before the monitor sees them good
  always @(posedge clk) begin
    on_reg[0] <= drive | early;
    on_reg[1] <= on_reg[0];
    on_reg[2] <= on_reg[1];
  end
  assign good = on_reg[2] & ~dead;
endmodule

// *** sps_sequencer_tb.sv ***
// Self-checking bench for the supply power-up sequencer.
// Uses short timing parameters; CE is dropped once to check the freeze.
`timescale 1ns/100ps
module sps_sequencer_tb;
  localparam int E = 20;
  localparam int M = 10;
  localparam int R = 10;
  localparam int G = 4;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic req = 1'b0;
  logic main_good = 1'b1;
  logic ce = 1'b1;
  logic tied = 1'b0;
  sps_pkg::sps_rails_type early = '0;
  sps_pkg::sps_rails_type dead = '0;
  wire sps_pkg::sps_rails_type en;
  wire sps_pkg::sps_rails_type good;
  wire logic rstn, fail, pdr, msl;
  wire [3:0] o = {en, rstn};
  int num_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  sps_sequencer #(.EN_DLY_CYC(E), .MON_WAIT_CYC(M), .RST_DLY_CYC(R),
    .GLITCH_CYC(G)) dut (.CLK(clk), .SYS_RST(sys_rst), .CE(ce),
    .PROJECTOR_POWER_REQUEST(req), .CORE_RAIL_GOOD(good.core),
    .MID_RAIL_GOOD(good.mid), .IO_RAIL_GOOD(good.io),
    .MAIN_INPUT_SUPPLY_GOOD(main_good), .CORE_RAIL_ENABLE(en.core),
    .MID_RAIL_ENABLE(en.mid), .IO_RAIL_ENABLE(en.io),
    .SYSTEM_RESET_N(rstn), .SEQUENCE_FAIL(fail),
    .POWER_DOWN_REQUEST(pdr), .MAIN_SUPPLY_LOW(msl));
  sps_rail_model u_rails (.clk(clk), .en(en), .early(early), .dead(dead),
    .tied(tied), .good(good));
  task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] y);
    checks_done++;
    if (y !== x) begin
      $display("MISMATCH %s exp %0h got %0h", nm, x, y);
      num_errors++;
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Counts cycles until output bit b rises and checks the span
  task automatic wt(input int b, input int lo, input int hi);
    int n;
    n = 0;
    while (o[b] !== 1'b1 && n <= hi) begin
      tick(1);
      n++;
    end
    chk("span", 1, n >= lo && n <= hi);
  endtask
  task automatic up();
    @(posedge clk);
    req <= 1'b1;
    wt(3, E - 1, E + 2);
    wt(2, M, M + 1);
    wt(1, M, M + 1);
    wt(0, M + R, M + R + 1);
  endtask
  task automatic scn_down();
    int n;
    n = 0;
    @(posedge clk);
    req <= 1'b0;
    while (pdr !== 1'b1 && n < G + 4) begin
      tick(1);
      n++;
    end
    chk("pulse", 1, pdr);
    tick(1);
    chk("pulse_end", 0, pdr);
    chk("outputs", 0, {o, fail});
  endtask
  task automatic scn_early();
    @(posedge clk);
    early <= '1;
    up();
    scn_down();
    @(posedge clk);
    early <= '0;
    tied <= 1'b1;
    up();
    scn_down();
    @(posedge clk);
    tied <= 1'b0;
  endtask
  task automatic scn_fail();
    @(posedge clk);
    dead.mid <= 1'b1;
    req <= 1'b1;
    wt(3, E - 1, E + 2);
    wt(2, M, M + 1);
    tick(M + 3);
    chk("fail", 8'h19, {o, fail});
    tick(4 * M);
    chk("fail_held", 8'h19, {o, fail});
    @(posedge clk);
    dead.mid <= 1'b0;
    scn_down();
    up();
  endtask
  // Mid-run reset clears every output; the held request restarts
  task automatic scn_reset();
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk("reset_outs", 0, {o, fail, pdr, msl});
    up();
  endtask
  // With CE low a dropped request must change nothing
  task automatic scn_hold();
    @(posedge clk);
    ce <= 1'b0;
    req <= 1'b0;
    tick(G + 4);
    chk("hold_outs", 8'h3c, {o, fail, pdr});
    @(posedge clk);
    ce <= 1'b1;
    req <= 1'b1;
    tick(G + 4);
    chk("hold_resume", 8'h3c, {o, fail, pdr});
  endtask
  task automatic scn_glitch();
    @(posedge clk);
    dead.core <= 1'b1;
    repeat (G - 1) @(posedge clk);
    dead.core <= 1'b0;
    tick(G + 4);
    chk("short_dip", 1, rstn);
    @(posedge clk);
    dead.io <= 1'b1;
    repeat (G + 2) @(posedge clk);
    dead.io <= 1'b0;
    tick(G + 4);
    chk("long_dip", 0, rstn);
    chk("dip_fail", 8'h1d, {o, fail});
    scn_down();
  endtask
  task automatic scn_main();
    @(posedge clk);
    main_good <= 1'b0;
    repeat (G - 1) @(posedge clk);
    main_good <= 1'b1;
    tick(G + 3);
    chk("main_glitch", 0, msl);
    @(posedge clk);
    main_good <= 1'b0;
    tick(G + 3);
    chk("main_low", 1, msl);
    @(posedge clk);
    main_good <= 1'b1;
    tick(G + 3);
    chk("main_back", 0, msl);
  endtask
  task automatic complete_run();
    if (num_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      complete_run();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    up();
    scn_down();
    scn_early();
    scn_fail();
    scn_reset();
    scn_hold();
    scn_glitch();
    scn_main();
    complete_run();
  end
endmodule
